/* src/ufc_fifo_line_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ufc_params.svh"
module ufc_fifo_line_ctrl import ufc_pkg::*; (
	input wire logic pclk, // functional clock
	input wire logic presetn, // async reset, low
	input wire logic ce, // clock enable
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // unmapped address
	input wire logic rx_char_valid, // received character offered
	input wire ufc_byte_t rx_char_data, // received character
	output logic rx_char_ready, // receive fifo takes it
	output logic tx_char_valid, // character for the shifter
	output ufc_byte_t tx_char_data, // head of transmit fifo
	input wire logic tx_char_ready, // shifter takes it
	input wire logic tx_serial_in, // serial bit from shifter
	output logic txd, // serial transmit pin
	output logic irq, // interrupt request
	output logic rx_dma_req, // receive dma request
	output logic tx_dma_req, // transmit dma request
	output ufc_byte_t line_format, // frame format fields
	output logic [15:0] divisor // baud divisor latches
);
	ufc_byte_t lcr_reg, lcr_next, dll_reg, dll_next, dlh_reg, dlh_next;
	logic [3:0] ier_reg, ier_next;
	logic fifo_en_reg, fifo_en_next, dma_sel_reg, dma_sel_next;
	logic [1:0] trig_reg, trig_next;
	ufc_ptr_t rx_wp_reg, rx_wp_next, rx_rp_reg, rx_rp_next;
	ufc_ptr_t tx_wp_reg, tx_wp_next, tx_rp_reg, tx_rp_next;
	ufc_level_t rx_cnt_reg, rx_cnt_next, tx_cnt_reg, tx_cnt_next;
	logic tx_settle_reg, tx_settle_next;
	ufc_bus_state_t bus_state, bus_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pslverr_reg, pslverr_next, txd_reg, txd_next;
	logic acc, wr_done, rd_done, divisor_latch_access, fcr_wr, mapped;
	logic hit_data, hit_ier, hit_iir, hit_lcr, hit_stat;
	logic rx_flush, tx_flush, rx_push, rx_pop, tx_push, tx_pop;
	logic rx_full, tx_full, rx_hit, dma_alt;
	ufc_level_t cap, trig_bytes;
	logic [3:0] iir_code;
	logic [31:0] iir_word;

	ufc_fifo_if rx_mem_if();
	ufc_fifo_if tx_mem_if();

	ufc_fifo_mem rx_mem (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.bus(rx_mem_if.store)
	);

	ufc_fifo_mem tx_mem (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.bus(tx_mem_if.store)
	);

	// apb decode; every access takes one wait state
	assign acc = psel & penable;
	assign pready = (bus_state == bus_ready);
	assign wr_done = acc & pready & pwrite;
	assign rd_done = acc & pready & ~pwrite;
	assign divisor_latch_access = lcr_reg[`UFC_LCR_DIVISOR_LATCH_ACCESS];
	assign hit_data = (paddr == `UFC_ADDR_DATA);
	assign hit_ier = (paddr == `UFC_ADDR_IER);
	assign hit_iir = (paddr == `UFC_ADDR_IIR);
	assign hit_lcr = (paddr == `UFC_ADDR_LCR);
	assign hit_stat = (paddr == `UFC_ADDR_STAT);
	assign mapped = hit_data | hit_ier | hit_iir | hit_lcr | hit_stat;
	assign fcr_wr = wr_done & hit_iir; // writes go to fifo control whatever divisor_latch_access

	// clear pulses; decoded from the write, nothing stored
	always_comb begin
		rx_flush = 1'b0;
		tx_flush = 1'b0;
		if (fcr_wr) begin
			if (pwdata[`UFC_FCR_EN]) begin
				// entering fifo mode starts from empty fifos
				rx_flush = pwdata[`UFC_FCR_RX_FIFO_FLUSH] | ~fifo_en_reg;
				tx_flush = pwdata[`UFC_FCR_TX_FIFO_FLUSH] | ~fifo_en_reg;
			end else begin
				rx_flush = 1'b1; // leaving fifo mode resets pointers
				tx_flush = 1'b1;
			end
		end
	end

	// trigger level decode
	always_comb begin
		unique case (trig_reg)
			2'h0: trig_bytes = `UFC_TRIG_B0;
			2'h1: trig_bytes = `UFC_TRIG_B1;
			2'h2: trig_bytes = `UFC_TRIG_B2;
			2'h3: trig_bytes = `UFC_TRIG_B3;
		endcase
	end

	// one holding slot in single-character mode
	assign cap = fifo_en_reg ? `UFC_DEPTH : 5'h01;
	assign rx_full = (rx_cnt_reg >= cap);
	assign tx_full = (tx_cnt_reg >= cap);
	// a character offered during a clear is held back, not lost
	assign rx_char_ready = ~rx_full & ~rx_flush;
	assign rx_push = rx_char_valid & rx_char_ready;
	assign rx_pop = rd_done & hit_data & ~divisor_latch_access & (rx_cnt_reg != 5'h00);
	assign tx_push = wr_done & hit_data & ~divisor_latch_access & ~tx_full & ~tx_flush;
	// head data settle one edge after any pointer move
	assign tx_char_valid = (tx_cnt_reg != 5'h00) & ~tx_settle_reg;
	assign tx_pop = tx_char_valid & tx_char_ready;
	assign tx_char_data = tx_mem_if.rd_data;

	// memory ports
	assign rx_mem_if.wr_en = rx_push;
	assign rx_mem_if.wr_data = rx_char_data;
	assign rx_mem_if.wr_addr = rx_wp_reg;
	assign rx_mem_if.rd_addr = rx_rp_reg;
	assign tx_mem_if.wr_en = tx_push;
	assign tx_mem_if.wr_data = pwdata[7:0];
	assign tx_mem_if.wr_addr = tx_wp_reg;
	assign tx_mem_if.rd_addr = tx_rp_reg;

	// level and request logic
	assign rx_hit = fifo_en_reg ? (rx_cnt_reg >= trig_bytes) : (rx_cnt_reg != 5'h00);
	// software is expected to keep dma select set
	assign dma_alt = fifo_en_reg & dma_sel_reg;
	assign rx_dma_req = dma_alt ? rx_hit : (rx_cnt_reg != 5'h00);
	assign tx_dma_req = dma_alt ? ~tx_full : (tx_cnt_reg == 5'h00);
	assign irq = (ier_reg[0] & rx_hit) | (ier_reg[1] & (tx_cnt_reg == 5'h00));

	// identification word; receive data outranks holding empty
	always_comb begin
		if (ier_reg[0] & rx_hit) begin
			iir_code = `UFC_IIR_RXDATA;
		end else if (ier_reg[1] & (tx_cnt_reg == 5'h00)) begin
			iir_code = `UFC_IIR_THRE;
		end else begin
			iir_code = `UFC_IIR_NONE;
		end
		iir_word = {24'h000000, (fifo_en_reg ? `UFC_IIR_FIFO : 2'h0), 2'h0, iir_code};
	end

	// control registers
	always_comb begin
		lcr_next = lcr_reg;
		ier_next = ier_reg;
		dll_next = dll_reg;
		dlh_next = dlh_reg;
		fifo_en_next = fifo_en_reg;
		dma_sel_next = dma_sel_reg;
		trig_next = trig_reg;
		if (wr_done & hit_lcr) begin
			lcr_next = pwdata[7:0];
		end
		if (wr_done & hit_ier) begin
			if (divisor_latch_access) begin
				dlh_next = pwdata[7:0];
			end else begin
				ier_next = pwdata[3:0];
			end
		end
		if (wr_done & hit_data & divisor_latch_access) begin
			dll_next = pwdata[7:0];
		end
		if (fcr_wr) begin
			fifo_en_next = pwdata[`UFC_FCR_EN];
			// other fields only land when enable is set in the same word
			if (pwdata[`UFC_FCR_EN]) begin
				dma_sel_next = pwdata[`UFC_FCR_DMA];
				trig_next = pwdata[`UFC_FCR_TRIG_HI:`UFC_FCR_TRIG_LO];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lcr_reg <= `UFC_LCR_RST;
			ier_reg <= `UFC_IER_RST;
			dll_reg <= `UFC_DL_RST;
			dlh_reg <= `UFC_DL_RST;
			fifo_en_reg <= 1'b0;
			dma_sel_reg <= 1'b0;
			trig_reg <= `UFC_TRIG_RST;
		end else if (ce) begin
			lcr_reg <= lcr_next;
			ier_reg <= ier_next;
			dll_reg <= dll_next;
			dlh_reg <= dlh_next;
			fifo_en_reg <= fifo_en_next;
			dma_sel_reg <= dma_sel_next;
			trig_reg <= trig_next;
		end
	end

	// fifo pointers; the shifter outside is never touched
	always_comb begin
		rx_wp_next = rx_wp_reg + ufc_ptr_t'(rx_push);
		rx_rp_next = rx_rp_reg + ufc_ptr_t'(rx_pop);
		rx_cnt_next = rx_cnt_reg + ufc_level_t'(rx_push) - ufc_level_t'(rx_pop);
		tx_wp_next = tx_wp_reg + ufc_ptr_t'(tx_push);
		tx_rp_next = tx_rp_reg + ufc_ptr_t'(tx_pop);
		tx_cnt_next = tx_cnt_reg + ufc_level_t'(tx_push) - ufc_level_t'(tx_pop);
		tx_settle_next = tx_push | tx_pop | tx_flush;
		if (rx_flush) begin
			rx_wp_next = 4'h0;
			rx_rp_next = 4'h0;
			rx_cnt_next = 5'h00;
		end
		if (tx_flush) begin
			tx_wp_next = 4'h0;
			tx_rp_next = 4'h0;
			tx_cnt_next = 5'h00;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_wp_reg <= 4'h0;
			rx_rp_reg <= 4'h0;
			rx_cnt_reg <= 5'h00;
			tx_wp_reg <= 4'h0;
			tx_rp_reg <= 4'h0;
			tx_cnt_reg <= 5'h00;
			tx_settle_reg <= 1'b0;
		end else if (ce) begin
			rx_wp_reg <= rx_wp_next;
			rx_rp_reg <= rx_rp_next;
			rx_cnt_reg <= rx_cnt_next;
			tx_wp_reg <= tx_wp_next;
			tx_rp_reg <= tx_rp_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_settle_reg <= tx_settle_next;
		end
	end

	// bus phase and read capture; wait state lets fifo read data settle
	always_comb begin
		bus_next = bus_state;
		prdata_next = prdata_reg;
		pslverr_next = pslverr_reg;
		unique case (bus_state)
			bus_setup: begin
				if (acc) begin
					bus_next = bus_ready;
					pslverr_next = ~mapped;
					prdata_next = 32'h00000000;
					if (~pwrite) begin
						if (hit_data) begin
							prdata_next = {24'h000000, (divisor_latch_access ? dll_reg : rx_mem_if.rd_data)};
						end else if (hit_ier) begin
							prdata_next = {24'h000000, (divisor_latch_access ? dlh_reg : {4'h0, ier_reg})};
						end else if (hit_iir) begin
							prdata_next = iir_word;
						end else if (hit_lcr) begin
							prdata_next = {24'h000000, lcr_reg};
						end else if (hit_stat) begin
							prdata_next = {14'h0000, dma_sel_reg, fifo_en_reg, 3'h0, tx_cnt_reg,
								3'h0, rx_cnt_reg};
						end
					end
				end
			end
			bus_ready: begin
				bus_next = bus_setup;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_state <= bus_setup;
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else if (ce) begin
			bus_state <= bus_next;
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// transmit pin; break forces spacing
	always_comb begin
		txd_next = lcr_reg[`UFC_LCR_BRK] ? 1'b0 : tx_serial_in;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txd_reg <= 1'b1;
		end else if (ce) begin
			txd_reg <= txd_next;
		end
	end

	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;
	assign txd = txd_reg;
	assign line_format = lcr_reg;
	assign divisor = {dlh_reg, dll_reg};

	// checks on enabled edges only
	default clocking cb @(posedge pclk iff ce);
	endclocking
	default disable iff (!presetn);

	trig_level_a: assert property (
		fifo_en_reg && ier_reg[0] && trig_reg == 2'h3 && rx_cnt_reg == 5'h0E |-> irq)
		else $error("trigger of fourteen bytes not honoured");
	rx_irq_drop_a: assert property (
		fifo_en_reg && !ier_reg[1] && rx_cnt_reg < trig_bytes |-> !irq)
		else $error("data-ready interrupt held below trigger");
	dma_basic_a: assert property (
		!fifo_en_reg |-> rx_dma_req == (rx_cnt_reg != 5'h00))
		else $error("alternate dma mode active outside fifo mode");
	tx_flush_a: assert property (
		fcr_wr && pwdata[`UFC_FCR_EN] && pwdata[`UFC_FCR_TX_FIFO_FLUSH] |=> tx_cnt_reg == 5'h00)
		else $error("transmit clear left characters");
	rx_keep_a: assert property (
		fcr_wr && fifo_en_reg && pwdata[`UFC_FCR_EN] && !pwdata[`UFC_FCR_RX_FIFO_FLUSH]
		&& !rx_push |=> rx_cnt_reg == $past(rx_cnt_reg))
		else $error("zero in receive clear changed the fifo");
	flush_line_a: assert property (
		tx_flush && !lcr_reg[`UFC_LCR_BRK] |=> txd == $past(tx_serial_in))
		else $error("clear disturbed the serial output");
	fcr_gate_a: assert property (
		fcr_wr && !pwdata[`UFC_FCR_EN] |=> trig_reg == $past(trig_reg) && !fifo_en_reg)
		else $error("field written without fifo enable");
	single_char_a: assert property (
		!fifo_en_reg |-> rx_cnt_reg <= 5'h01 && tx_cnt_reg <= 5'h01)
		else $error("more than one character outside fifo mode");
	iir_zero_a: assert property (
		bus_state == bus_setup && acc && !pwrite && hit_iir |=> prdata[31:8] == 24'h000000
		&& prdata[5:4] == 2'h0)
		else $error("reserved identification bits not zero");
	lcr_back_a: assert property (
		wr_done && hit_lcr |=> line_format == $past(pwdata[7:0]))
		else $error("line format not stored as written");
	iir_read_a: assert property (
		bus_state == bus_setup && acc && !pwrite && hit_iir |=> prdata[3:0] == $past(iir_code))
		else $error("shared address did not read identification");
	dll_route_a: assert property (
		wr_done && hit_data && divisor_latch_access |=> divisor[7:0] == $past(pwdata[7:0])
		&& tx_cnt_reg <= $past(tx_cnt_reg))
		else $error("divisor_latch_access write reached the transmit fifo");
	break_low_a: assert property (
		lcr_reg[`UFC_LCR_BRK] |=> !txd)
		else $error("break did not hold the line low");
	flush_pulse_a: assert property (
		rx_flush |=> !rx_flush ##1 !rx_flush)
		else $error("receive clear stuck high");

	rx_irq_c: cover property (fifo_en_reg && ier_reg[0] && trig_reg == 2'h2 && irq);
	tx_flush_c: cover property (tx_flush && tx_cnt_reg > 5'h02);
	break_c: cover property (lcr_reg[`UFC_LCR_BRK] && !txd);
	rx_full_c: cover property (fifo_en_reg && rx_full);
endmodule
`default_nettype wire

/* pkg/ufc_params.svh */
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH
// Function
// - receive trigger field bits 7-6 of fifo_control select 1, 4, 8 or 14 bytes for codes 0 to 3h.
// - receive data-ready interrupt rises when the fill reaches the trigger level and falls below it.
// - dma mode select picks the alternate request mode when set, basic when clear, only in fifo mode.
// - writing one to bit 2 empties the transmit fifo and its counter; zero does nothing (the code still empties it with enable clear or on entering fifo mode).
// - writing one to bit 1 empties the receive fifo and its counter; zero does nothing (the code still empties it with enable clear or on entering fifo mode).
// - a fifo clear never touches the serial shift register or the character inside it.
// - other fifo_control fields are ignored unless the same write sets the enable bit 0.
// - with fifo enable clear the block is single-character and pointers and counters reset.
// - fifo_control fields are write-only, reset to zero, and bits 31-8 and 5-4 read as zero.
// - line_format_control holds divisor_latch_access 7, break 6, stick 5, even 4, parity 3, stop 2, length 1-0.
// - line_format_control reads back exactly what was written.
// - the fifo_control address reads interrupt identification and writes fifo control.
// - divisor latch access routes the data and enable addresses to the divisor latches.
// - while break control is set the serial transmit output is forced low.

// register byte addresses
`define UFC_ADDR_DATA 8'h00
`define UFC_ADDR_IER 8'h04
`define UFC_ADDR_IIR 8'h08
`define UFC_ADDR_LCR 8'h0C
`define UFC_ADDR_STAT 8'h10

// fifo_control fields
`define UFC_FCR_EN 0
`define UFC_FCR_RX_FIFO_FLUSH 1
`define UFC_FCR_TX_FIFO_FLUSH 2
`define UFC_FCR_DMA 3
`define UFC_FCR_TRIG_LO 6
`define UFC_FCR_TRIG_HI 7

// line_format_control fields
`define UFC_LCR_DIVISOR_LATCH_ACCESS 7
`define UFC_LCR_BRK 6

// reset values
`define UFC_LCR_RST 8'h00
`define UFC_IER_RST 4'h0
`define UFC_DL_RST 8'h00
`define UFC_TRIG_RST 2'h0

// trigger levels in bytes
`define UFC_TRIG_B0 5'h01
`define UFC_TRIG_B1 5'h04
`define UFC_TRIG_B2 5'h08
`define UFC_TRIG_B3 5'h0E

// fifo geometry
`define UFC_DEPTH 5'h10
`define UFC_AW 4

// identification codes
`define UFC_IIR_NONE 4'h1
`define UFC_IIR_RXDATA 4'h4
`define UFC_IIR_THRE 4'h2
`define UFC_IIR_FIFO 2'h3
`endif

/* pkg/ufc_pkg.sv */
package ufc_pkg;
	typedef logic [7:0] ufc_byte_t;
	typedef logic [3:0] ufc_ptr_t;
	typedef logic [4:0] ufc_level_t;
	typedef enum {bus_setup, bus_ready} ufc_bus_state_t;
endpackage

/* pkg/ufc_fifo_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface ufc_fifo_if;
	logic wr_en;
	ufc_pkg::ufc_byte_t wr_data;
	ufc_pkg::ufc_ptr_t wr_addr;
	ufc_pkg::ufc_ptr_t rd_addr;
	ufc_pkg::ufc_byte_t rd_data;
	modport ctrl (output wr_en, wr_data, wr_addr, rd_addr, input rd_data);
	modport store (input wr_en, wr_data, wr_addr, rd_addr, output rd_data);
endinterface
`default_nettype wire

/* src/ufc_fifo_mem.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ufc_params.svh"
module ufc_fifo_mem import ufc_pkg::*; (
	input wire logic pclk, // functional clock
	input wire logic presetn, // async reset, low
	input wire logic ce, // clock enable
	ufc_fifo_if.store bus // write port and registered read
);
	ufc_byte_t cell_reg [`UFC_DEPTH];
	ufc_byte_t rd_reg;

	// storage carries no reset; only the read register does
	always_ff @(posedge pclk) begin
		if (ce && bus.wr_en) begin
			cell_reg[bus.wr_addr] <= bus.wr_data;
		end
	end

	// read data lag the address by one edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_reg <= 8'h00;
		end else if (ce) begin
			rd_reg <= cell_reg[bus.rd_addr];
		end
	end

	assign bus.rd_data = rd_reg;
endmodule
`default_nettype wire

/* bench/ufc_line_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module ufc_line_partner import ufc_pkg::*; (
	input wire logic pclk, // functional clock
	input wire logic presetn, // async reset, low
	input wire logic load, // pulse: add a budget
	input wire logic [4:0] budget, // characters to offer
	input wire logic take_en, // accept transmit bytes
	output logic rx_char_valid, // character offered
	output ufc_byte_t rx_char_data, // offered character
	input wire logic rx_char_ready, // block takes it
	input wire logic tx_char_valid, // block offers a byte
	input wire ufc_byte_t tx_char_data, // offered byte
	output logic tx_char_ready, // we take it
	output logic tx_serial_in, // shifter bit
	output ufc_byte_t last_tx // last byte taken
);
	logic [4:0] left_reg;
	ufc_byte_t seq_reg;
	// idle data shows the inverse so a stale byte never passes for a fresh one
	assign rx_char_valid = (left_reg != 5'h00);
	assign rx_char_data = rx_char_valid ? seq_reg : ~seq_reg;
	assign tx_char_ready = take_en;
	// offer one character a cycle; shifter bit toggles so delays show
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_reg <= 5'h00;
			seq_reg <= 8'h10;
			last_tx <= 8'h00;
			tx_serial_in <= 1'b1;
		end else begin
			tx_serial_in <= ~tx_serial_in;
			// a take in the load cycle still counts, so no extra character slips out
			left_reg <= left_reg + (load ? budget : 5'h00) - {4'h0, rx_char_valid && rx_char_ready};
			if (rx_char_valid && rx_char_ready) begin
				seq_reg <= seq_reg + 8'h01;
			end
			if (tx_char_valid && tx_char_ready) begin
				last_tx <= tx_char_data;
			end
		end
	end
endmodule
`default_nettype wire

/* bench/uart_fifo_and_line_control_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ufc_params.svh"
module uart_fifo_and_line_control_test;
	import ufc_pkg::*;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, txd, irq, err;
	logic rx_char_valid, rx_char_ready, tx_char_valid, tx_char_ready, tx_serial_in;
	logic rx_dma_req, tx_dma_req, load, take_en;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] budget;
	logic [15:0] divisor;
	ufc_byte_t rx_char_data, tx_char_data, line_format, last_tx;
	logic [4:0] lv [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
	logic [31:0] lf [3] = '{32'hFFFFFF5A, 32'h000000A5, 32'h0000003F};
	// first character of each trigger round, counted from the partner's start value
	logic [7:0] fd [4] = '{8'h10, 8'h11, 8'h15, 8'h1D};
	int bad_count = 0;
	int checks = 0;
	always #25 pclk = ~pclk;
	ufc_fifo_line_ctrl i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_char_valid(rx_char_valid),
		.rx_char_data(rx_char_data), .rx_char_ready(rx_char_ready),
		.tx_char_valid(tx_char_valid), .tx_char_data(tx_char_data),
		.tx_char_ready(tx_char_ready), .tx_serial_in(tx_serial_in), .txd(txd), .irq(irq),
		.rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req), .line_format(line_format),
		.divisor(divisor));
	ufc_line_partner i_far (.pclk(pclk), .presetn(presetn), .load(load), .budget(budget),
		.take_en(take_en), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
		.rx_char_ready(rx_char_ready), .tx_char_valid(tx_char_valid),
		.tx_char_data(tx_char_data), .tx_char_ready(tx_char_ready),
		.tx_serial_in(tx_serial_in), .last_tx(last_tx));
	task automatic tally_and_finish();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer; entered just after a rising edge, leaves one idle cycle
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (n >= 20) begin
			chk("pready", 32'h1, 32'h0);
			tally_and_finish();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// poll status until it shows the wanted counts, bounded
	task automatic wait_stat(input logic [31:0] exp);
		for (int i = 0; i < 40; i++) begin
			apb(`UFC_ADDR_STAT, 1'b0, 32'h0);
			if (rd === exp) return;
		end
		chk("status", exp, rd);
		tally_and_finish();
	endtask
	task automatic feed(input logic [4:0] n);
		load <= 1'b1;
		budget <= n;
		@(posedge pclk);
		load <= 1'b0;
	endtask
	initial begin
		repeat (100000) @(posedge pclk);
		bad_count++;
		tally_and_finish();
	end
	initial begin
		{presetn, psel, penable, pwrite, load, take_en} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		budget = 5'h00;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("txd idle", 32'h1, txd);
		apb(`UFC_ADDR_LCR, 1'b0, 32'h0);
		chk("lcr reset", 32'h0, rd);
		apb(`UFC_ADDR_IIR, 1'b0, 32'h0);
		chk("ident reset", 32'h1, rd);
		// reserved upper bits must not stick
		for (int i = 0; i < 3; i++) begin
			apb(`UFC_ADDR_LCR, 1'b1, lf[i]);
			apb(`UFC_ADDR_LCR, 1'b0, 32'h0);
			chk("lcr readback", {24'h0, lf[i][7:0]}, rd);
			chk("line_format", {24'h0, lf[i][7:0]}, line_format);
		end
		apb(`UFC_ADDR_LCR, 1'b1, 32'h83);
		apb(`UFC_ADDR_DATA, 1'b1, 32'h34);
		apb(`UFC_ADDR_IER, 1'b1, 32'h12);
		chk("divisor", 32'h1234, divisor);
		apb(`UFC_ADDR_LCR, 1'b1, 32'h03);
		apb(`UFC_ADDR_IER, 1'b1, 32'h3);
		apb(`UFC_ADDR_IER, 1'b0, 32'h0);
		chk("enable reg", 32'h3, rd);
		chk("divisor kept", 32'h1234, divisor);
		apb(`UFC_ADDR_IER, 1'b1, 32'h1);
		apb(`UFC_ADDR_LCR, 1'b1, 32'h43);
		@(posedge pclk);
		chk("txd break", 32'h0, txd);
		apb(`UFC_ADDR_LCR, 1'b1, 32'h03);
		@(posedge pclk);
		chk("txd follows", {31'h0, ~tx_serial_in}, txd);
		@(posedge pclk);
		// fields without the enable bit are dropped
		apb(`UFC_ADDR_IIR, 1'b1, 32'hC8);
		wait_stat(32'h0);
		apb(`UFC_ADDR_IIR, 1'b1, 32'h09);
		wait_stat(32'h30000);
		// each trigger code: just below, at, then one below again
		for (int c = 0; c < 4; c++) begin
			apb(`UFC_ADDR_IIR, 1'b1, {24'h0, c[1:0], 6'h0B});
			feed(lv[c] - 5'h01);
			wait_stat({27'h1800, lv[c] - 5'h01});
			chk("irq below", 32'h0, irq);
			chk("rx dma below", 32'h0, rx_dma_req);
			feed(5'h01);
			wait_stat({27'h1800, lv[c]});
			chk("irq at level", 32'h1, irq);
			chk("rx dma at level", 32'h1, rx_dma_req);
			apb(`UFC_ADDR_IIR, 1'b0, 32'h0);
			chk("ident rx", 32'hC4, rd);
			apb(`UFC_ADDR_DATA, 1'b0, 32'h0);
			chk("rx data", {24'h0, fd[c]}, rd);
			chk("irq dropped", 32'h0, irq);
		end
		apb(`UFC_ADDR_IIR, 1'b1, 32'hC9);
		wait_stat(32'h3000D);
		apb(`UFC_ADDR_IIR, 1'b1, 32'hCB);
		wait_stat(32'h30000);
		apb(`UFC_ADDR_IIR, 1'b1, 32'hC9);
		feed(5'h02);
		wait_stat(32'h30002);
		// transmit side stalled by the far end, then flushed
		apb(`UFC_ADDR_DATA, 1'b1, 32'h11);
		apb(`UFC_ADDR_DATA, 1'b1, 32'h22);
		apb(`UFC_ADDR_DATA, 1'b1, 32'h33);
		wait_stat(32'h30302);
		chk("tx dma alt", 32'h1, tx_dma_req);
		apb(`UFC_ADDR_IIR, 1'b1, 32'hCD);
		wait_stat(32'h30002);
		take_en <= 1'b1;
		apb(`UFC_ADDR_DATA, 1'b1, 32'h5C);
		wait_stat(32'h30002);
		chk("sent byte", 32'h5C, last_tx);
		apb(`UFC_ADDR_IIR, 1'b1, 32'hC1);
		wait_stat(32'h10002);
		chk("rx dma basic", 32'h1, rx_dma_req);
		chk("tx dma basic", 32'h1, tx_dma_req);
		apb(`UFC_ADDR_IIR, 1'b1, 32'h00);
		wait_stat(32'h0);
		apb(`UFC_ADDR_IIR, 1'b1, 32'h08);
		wait_stat(32'h0);
		feed(5'h03);
		wait_stat(32'h1);
		repeat (5) @(posedge pclk);
		wait_stat(32'h1);
		apb(8'h14, 1'b0, 32'h0);
		chk("unmapped err", 32'h1, err);
		chk("unmapped data", 32'h0, rd);
		tally_and_finish();
	end
endmodule
`default_nettype wire
